// ### logic/mbe_pkg.sv
// package: opcodes, instruction carrier and constants of the executor
package mbe_pkg;
   localparam int PC_W = 12;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 8;
   localparam int PM_W = 15;
   localparam int BIT_W = 3;
   localparam int CYC_W = 3;
   localparam int SP_W = 3;
   localparam int STACK_DEPTH = 6;
   localparam int DMEM_DEPTH = 192;
   // one instruction cycle is this many system clocks
   localparam int CLK_PER_ICYC = 4;
   localparam logic [ADDR_W-1:0] PCL_ADDR = 8'h06;
   localparam logic [3:0] LAST_PAGE = 4'hF;
   localparam logic [PC_W-1:0] PC_RST = 12'h000;
   localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
   localparam logic [DATA_W-1:0] BYTE_ONES = 8'hFF;
   localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
   localparam logic [CYC_W-1:0] CYC_ONE = 3'h1;
   localparam logic [CYC_W-1:0] CYC_TWO = 3'h2;
   localparam logic [SP_W-1:0] SP_RST = 3'h0;
   localparam logic [SP_W-1:0] SP_TOP = 3'(STACK_DEPTH - 1);

   typedef enum logic [4:0] {
      OP_NOP, OP_TRANSFER_M_TO_A, OP_TRANSFER_A_TO_M, OP_TRANSFER_X_TO_A,
      OP_BIT_CLEAR, OP_BIT_SET, OP_BYTE_CLEAR, OP_BYTE_SET,
      OP_SKIP_IF_BYTE_ZERO, OP_SKIP_ZERO_WITH_COPY, OP_SKIP_BIT_ZERO,
      OP_SKIP_BIT_ONE, OP_INC_SKIP_ZERO, OP_DEC_SKIP_ZERO,
      OP_INC_SKIP_ZERO_TO_W, OP_DEC_SKIP_ZERO_TO_W,
      OP_UNCONDITIONAL_BRANCH, OP_CALL, OP_SUBROUTINE_EXIT,
      OP_RETURN_LITERAL, OP_INTERRUPT_EXIT,
      OP_TABLE_FETCH_CURRENT_PAGE, OP_TABLE_FETCH_FINAL_PAGE,
      OP_NIBBLE_EXCHANGE, OP_NIBBLE_EXCHANGE_TO_W,
      OP_WATCHDOG_KICK, OP_WATCHDOG_PRECLEAR_A, OP_WATCHDOG_PRECLEAR_B,
      OP_HALT
   } mbe_op_t;

   typedef struct packed {
      mbe_op_t op;
      logic [ADDR_W-1:0] addr;
      logic [BIT_W-1:0] bit_sel;
      logic [DATA_W-1:0] imm;
      logic [PC_W-1:0] target;
   } mbe_instr_t;

   function automatic logic [DATA_W-1:0] mbe_swap(
      input logic [DATA_W-1:0] v);
      return {v[3:0], v[7:4]};
   endfunction

   function automatic logic [DATA_W-1:0] mbe_bit_mask(
      input logic [BIT_W-1:0] i);
      return 8'h01 << i;
   endfunction
endpackage

// ### logic/mbe_tick_div.sv
// divider giving one enable pulse per instruction cycle
`timescale 1ns/1ps
`default_nettype none
module mbe_tick_div
   import mbe_pkg::*;
#(
   parameter int DIV = CLK_PER_ICYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // enable out
   output logic tick_reg
);
   localparam int CW = $clog2(DIV);
   localparam logic [CW-1:0] CNT_LAST = CW'(DIV - 1);
   localparam logic [CW-1:0] CNT_RST = '0;

   logic [CW-1:0] cnt_reg;
   wire logic [CW-1:0] cnt_next;
   wire logic wrap;

   assign wrap = (cnt_reg == CNT_LAST);
   assign cnt_next = wrap ? CNT_RST : CW'(cnt_reg + 1'b1);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg <= CNT_RST;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         tick_reg <= wrap;
      end
   end
endmodule // mbe_tick_div
`default_nettype wire

// ### logic/mbe_dmem.sv
// data memory with registered read port
`timescale 1ns/1ps
`default_nettype none
module mbe_dmem
   import mbe_pkg::*;
#(
   parameter int DEPTH = DMEM_DEPTH,
   parameter int WIDTH = DATA_W
) (
   // clock
   input wire logic clk,
   // write port
   input wire logic we,
   input wire logic [ADDR_W-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   // read port
   input wire logic [ADDR_W-1:0] raddr,
   output logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem [DEPTH];
   wire logic rd_in_range;
   wire logic wr_in_range;

   // unimplemented addresses read zero and drop writes
   assign rd_in_range = (32'(raddr) < DEPTH);
   assign wr_in_range = (32'(waddr) < DEPTH);

   always_ff @(posedge clk) begin
      if (we && wr_in_range) begin
         mem[waddr] <= wdata;
      end
      rdata <= rd_in_range ? mem[raddr] : '0;
   end
endmodule // mbe_dmem
`default_nettype wire

// ### logic/mbe_exec.sv
// executor for move, bit, skip, branch, table, swap and watchdog opcodes
//
// Behaviour
// RULE1: moves copy memory to acc, acc to memory, immediate to acc; one cycle.
// RULE2: bit clear/set changes selected bit 0..7 of a byte in one cycle.
// RULE3: writing the pc low byte adds one instruction cycle.
// RULE4: a taken skip adds one instruction cycle; otherwise no change.
// RULE5: skip_if_byte_zero skips when byte is zero, one cycle otherwise.
// RULE6: skip_zero_with_copy also loads the tested byte into acc.
// RULE7: bit skips test a selected bit for zero or for one.
// RULE8: inc/dec skips write memory back; both penalties may apply.
// RULE9: inc/dec skip to acc leave memory alone, skip on zero result.
// RULE10: branch, call, subroutine and interrupt exit take two cycles.
// RULE11: return with literal also loads immediate into acc.
// RULE12: table fetch writes low byte to memory, upper bits to latch; two cycles.
// RULE13: nibble exchange swaps in place or into acc, one cycle.
// RULE14: preclear clears expiry and powerdown flags only if dog is cleared.
// RULE15: preclear without a dog clear leaves both flags unchanged.
// RULE16: halt enters power down in one cycle and updates both flags.
// RULE17: watchdog kick clears the dog and both flags in one cycle.
`timescale 1ns/1ps
`default_nettype none
module mbe_exec
   import mbe_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // instruction in
   input wire logic instr_valid,
   input wire mbe_instr_t instr,
   output logic instr_ack_reg,
   output logic done_reg,
   output logic skip_reg,
   // program memory
   output logic [PC_W-1:0] pm_addr_reg,
   input wire logic [PM_W-1:0] pm_data,
   input wire logic [DATA_W-1:0] tblp,
   // watchdog and power
   input wire logic dog_timeout,
   input wire logic wake_pin,
   output logic dog_clear_reg,
   output logic power_down_reg,
   output logic dog_expiry_flag_reg,
   output logic powerdown_flag_reg,
   // core state
   output logic [DATA_W-1:0] acc_reg,
   output logic [PC_W-1:0] pc_reg,
   output logic [PM_W-DATA_W-1:0] table_high_latch_reg,
   output logic int_exit_reg
);
   // ****************************************
   // sequencer
   // ****************************************
   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_EXEC, ST_WAIT} mbe_st_t;

   mbe_st_t st_reg;
   mbe_instr_t ir_reg;
   logic [CYC_W-1:0] left_reg;
   logic wake_meta_reg;
   logic wake_sync_reg;
   logic seen_a_reg;
   logic seen_b_reg;
   logic [PC_W-1:0] stack_reg [STACK_DEPTH];
   logic [SP_W-1:0] sp_reg;
   wire logic tick;
   wire logic last;
   wire logic accept;
   wire logic exec;
   wire logic [DATA_W-1:0] ram_rdata;

   mbe_tick_div #(.DIV(CLK_PER_ICYC)) u_div (
      .clk(clk),
      .rst_b(rst_b),
      .tick_reg(tick)
   );

   // instructions start only on an instruction-cycle boundary
   assign last = (st_reg == ST_WAIT) && tick && (left_reg == CYC_ONE);
   assign accept = tick && instr_valid && !power_down_reg &&
                   ((st_reg == ST_IDLE) || last);
   assign exec = (st_reg == ST_EXEC);

   // ****************************************
   // operand and result decode
   // ****************************************
   logic [DATA_W-1:0] res;
   logic mem_wr;
   logic acc_wr;
   logic skip;
   logic [CYC_W-1:0] base;
   wire logic [DATA_W-1:0] rd;
   wire logic [DATA_W-1:0] mask;
   wire logic [DATA_W-1:0] inc;
   wire logic [DATA_W-1:0] dec;
   wire logic pcl_wr;
   wire logic ram_we;
   wire logic [CYC_W-1:0] cycles;

   // the pc low byte is not in ram, reads see the live counter
   assign rd = (ir_reg.addr == PCL_ADDR) ? pc_reg[DATA_W-1:0] : ram_rdata;
   assign mask = mbe_bit_mask(ir_reg.bit_sel);
   assign inc = DATA_W'(rd + 1'b1);
   assign dec = DATA_W'(rd - 1'b1);

   always_comb begin
      res = rd;
      mem_wr = 1'b0;
      acc_wr = 1'b0;
      skip = 1'b0;
      base = CYC_ONE;
      unique case (ir_reg.op)
         OP_TRANSFER_M_TO_A: acc_wr = 1'b1; // see RULE1
         OP_TRANSFER_A_TO_M: begin
            res = acc_reg; // see RULE1
            mem_wr = 1'b1;
         end
         OP_TRANSFER_X_TO_A: begin
            res = ir_reg.imm; // see RULE1
            acc_wr = 1'b1;
         end
         OP_BIT_CLEAR: begin
            res = rd & ~mask; // see RULE2
            mem_wr = 1'b1;
         end
         OP_BIT_SET: begin
            res = rd | mask; // see RULE2
            mem_wr = 1'b1;
         end
         OP_BYTE_CLEAR: begin
            res = BYTE_ZERO;
            mem_wr = 1'b1;
         end
         OP_BYTE_SET: begin
            res = BYTE_ONES;
            mem_wr = 1'b1;
         end
         OP_SKIP_IF_BYTE_ZERO: skip = (rd == BYTE_ZERO); // see RULE5
         OP_SKIP_ZERO_WITH_COPY: begin
            acc_wr = 1'b1; // see RULE6
            skip = (rd == BYTE_ZERO);
         end
         OP_SKIP_BIT_ZERO: skip = ((rd & mask) == BYTE_ZERO); // see RULE7
         OP_SKIP_BIT_ONE: skip = ((rd & mask) != BYTE_ZERO); // see RULE7
         OP_INC_SKIP_ZERO: begin
            res = inc; // see RULE8
            mem_wr = 1'b1;
            skip = (inc == BYTE_ZERO);
         end
         OP_DEC_SKIP_ZERO: begin
            res = dec; // see RULE8
            mem_wr = 1'b1;
            skip = (dec == BYTE_ZERO);
         end
         OP_INC_SKIP_ZERO_TO_W: begin
            res = inc; // see RULE9
            acc_wr = 1'b1;
            skip = (inc == BYTE_ZERO);
         end
         OP_DEC_SKIP_ZERO_TO_W: begin
            res = dec; // see RULE9
            acc_wr = 1'b1;
            skip = (dec == BYTE_ZERO);
         end
         OP_UNCONDITIONAL_BRANCH, OP_CALL, OP_SUBROUTINE_EXIT,
         OP_INTERRUPT_EXIT: base = CYC_TWO; // see RULE10
         OP_RETURN_LITERAL: begin
            base = CYC_TWO; // see RULE10 RULE11
            res = ir_reg.imm;
            acc_wr = 1'b1;
         end
         OP_TABLE_FETCH_CURRENT_PAGE, OP_TABLE_FETCH_FINAL_PAGE: begin
            base = CYC_TWO; // see RULE12
            res = pm_data[DATA_W-1:0];
            mem_wr = 1'b1;
         end
         OP_NIBBLE_EXCHANGE: begin
            res = mbe_swap(rd); // see RULE13
            mem_wr = 1'b1;
         end
         OP_NIBBLE_EXCHANGE_TO_W: begin
            res = mbe_swap(rd); // see RULE13
            acc_wr = 1'b1;
         end
         default: ; // nop, watchdog, halt and unused codes
      endcase
   end

   assign pcl_wr = mem_wr && (ir_reg.addr == PCL_ADDR);
   assign ram_we = exec && mem_wr && !pcl_wr;
   // both penalties stack on the base count
   assign cycles = CYC_W'(base + {2'b00, pcl_wr} + {2'b00, skip}); // see RULE3 RULE4 RULE8

   mbe_dmem #(.DEPTH(DMEM_DEPTH), .WIDTH(DATA_W)) u_dmem (
      .clk(clk),
      .we(ram_we),
      .waddr(ir_reg.addr),
      .wdata(res),
      .raddr(ir_reg.addr),
      .rdata(ram_rdata)
   );

   // ****************************************
   // program counter and stack
   // ****************************************
   wire logic is_call;
   wire logic is_ret;
   wire logic [SP_W-1:0] sp_up;
   wire logic [SP_W-1:0] sp_down;
   wire logic [PC_W-1:0] pc_next;

   assign is_call = (ir_reg.op == OP_CALL);
   assign is_ret = (ir_reg.op == OP_SUBROUTINE_EXIT) ||
                   (ir_reg.op == OP_RETURN_LITERAL) ||
                   (ir_reg.op == OP_INTERRUPT_EXIT);
   // circular stack: a seventh call overwrites the oldest entry
   assign sp_up = (sp_reg == SP_TOP) ? SP_RST : SP_W'(sp_reg + 1'b1);
   assign sp_down = (sp_reg == SP_RST) ? SP_TOP : SP_W'(sp_reg - 1'b1);
   assign pc_next =
      pcl_wr ? {pc_reg[PC_W-1:DATA_W], res} : // see RULE3
      (is_call || ir_reg.op == OP_UNCONDITIONAL_BRANCH) ? ir_reg.target :
      is_ret ? stack_reg[sp_down] :
      skip ? PC_W'(pc_reg + 2'd2) : PC_W'(pc_reg + 1'b1); // see RULE4

   // ****************************************
   // watchdog and power down
   // ****************************************
   wire logic op_kick;
   wire logic op_pa;
   wire logic op_pb;
   wire logic op_halt;
   wire logic pre_clear_now;
   wire logic dog_clear_now;

   assign op_kick = exec && (ir_reg.op == OP_WATCHDOG_KICK);
   assign op_pa = exec && (ir_reg.op == OP_WATCHDOG_PRECLEAR_A);
   assign op_pb = exec && (ir_reg.op == OP_WATCHDOG_PRECLEAR_B);
   assign op_halt = exec && (ir_reg.op == OP_HALT);
   // a preclear clears the dog only once both halves have run; kick and halt clear it at once
   assign pre_clear_now = (op_pa && seen_b_reg) || (op_pb && seen_a_reg);
   assign dog_clear_now = op_kick || op_halt || pre_clear_now;

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= ST_IDLE;
         ir_reg <= '0;
         left_reg <= CYC_ONE;
         instr_ack_reg <= 1'b0;
         done_reg <= 1'b0;
         skip_reg <= 1'b0;
         pm_addr_reg <= PC_RST;
      end else begin
         instr_ack_reg <= accept;
         done_reg <= last;
         skip_reg <= exec && skip;
         if (accept) begin
            st_reg <= ST_READ;
            ir_reg <= instr;
            pm_addr_reg <= (instr.op == OP_TABLE_FETCH_FINAL_PAGE) ?
                           {LAST_PAGE, tblp} :
                           {pc_reg[PC_W-1:DATA_W], tblp}; // see RULE12
         end else if (last) begin
            st_reg <= ST_IDLE;
         end else if (st_reg == ST_READ) begin
            st_reg <= ST_EXEC;
         end else if (exec) begin
            st_reg <= ST_WAIT;
            left_reg <= cycles;
         end else if ((st_reg == ST_WAIT) && tick) begin
            left_reg <= CYC_W'(left_reg - 1'b1);
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         acc_reg <= ACC_RST;
         pc_reg <= PC_RST;
         table_high_latch_reg <= '0;
         sp_reg <= SP_RST;
         int_exit_reg <= 1'b0;
      end else begin
         int_exit_reg <= exec && (ir_reg.op == OP_INTERRUPT_EXIT);
         if (exec) begin
            pc_reg <= pc_next;
            if (acc_wr) begin
               acc_reg <= res;
            end
            if (base == CYC_TWO && mem_wr) begin
               table_high_latch_reg <= pm_data[PM_W-1:DATA_W]; // see RULE12
            end
            if (is_call) begin
               sp_reg <= sp_up;
            end else if (is_ret) begin
               sp_reg <= sp_down;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (exec && is_call) begin
         stack_reg[sp_reg] <= PC_W'(pc_reg + 1'b1);
      end
   end

   // expiry from the dog wins over a clear in the same cycle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wake_meta_reg <= 1'b0;
         wake_sync_reg <= 1'b0;
         seen_a_reg <= 1'b0;
         seen_b_reg <= 1'b0;
         dog_clear_reg <= 1'b0;
         power_down_reg <= 1'b0;
         dog_expiry_flag_reg <= 1'b0;
         powerdown_flag_reg <= 1'b0;
      end else begin
         wake_meta_reg <= wake_pin;
         wake_sync_reg <= wake_meta_reg;
         dog_clear_reg <= dog_clear_now; // see RULE14 RULE17
         seen_a_reg <= !dog_clear_now && (seen_a_reg || op_pa);
         seen_b_reg <= !dog_clear_now && (seen_b_reg || op_pb);
         if (dog_timeout) begin
            dog_expiry_flag_reg <= 1'b1;
         end else if (dog_clear_now) begin
            dog_expiry_flag_reg <= 1'b0; // see RULE14 RULE15 RULE16 RULE17
         end
         if (op_halt) begin
            powerdown_flag_reg <= 1'b1; // see RULE16
         end else if (op_kick || pre_clear_now) begin
            powerdown_flag_reg <= 1'b0; // see RULE14 RULE15 RULE17
         end
         if (op_halt) begin
            power_down_reg <= 1'b1; // see RULE16
         end else if (wake_sync_reg) begin
            power_down_reg <= 1'b0;
         end
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   property p_move_time;
      accept && instr.op == OP_TRANSFER_M_TO_A |-> ##5 done_reg;
   endproperty
   a_move_time: assert property (p_move_time) // see RULE1
      else $error("move from memory did not end after one cycle");
   property p_imm_acc;
      accept && instr.op == OP_TRANSFER_X_TO_A
         |-> ##3 acc_reg == $past(instr.imm, 3);
   endproperty
   a_imm_acc: assert property (p_imm_acc) // see RULE1
      else $error("immediate not loaded into acc");
   property p_bit_clear;
      exec && ir_reg.op == OP_BIT_CLEAR && !pcl_wr
         |-> ram_we && !res[ir_reg.bit_sel] ##1 $stable(acc_reg);
   endproperty
   a_bit_clear: assert property (p_bit_clear) // see RULE2
      else $error("bit clear wrong");
   property p_pcl_penalty;
      accept && instr.op == OP_TRANSFER_A_TO_M && instr.addr == PCL_ADDR
         |-> ##2 !done_reg [*7] ##1 done_reg;
   endproperty
   a_pcl_penalty: assert property (p_pcl_penalty) // see RULE3
      else $error("pc low write lacks extra cycle");
   property p_skip_penalty;
      exec && skip && !pcl_wr && base == CYC_ONE |-> ##7 done_reg;
   endproperty
   a_skip_penalty: assert property (p_skip_penalty) // see RULE4
      else $error("skip lacks extra cycle");
   property p_copy_skip;
      exec && ir_reg.op == OP_SKIP_ZERO_WITH_COPY
         |=> acc_reg == $past(rd) && skip_reg == ($past(rd) == BYTE_ZERO);
   endproperty
   a_copy_skip: assert property (p_copy_skip) // see RULE6
      else $error("copy skip wrong");
   property p_inc_to_w;
      exec && ir_reg.op == OP_INC_SKIP_ZERO_TO_W
         |-> !ram_we ##1 acc_reg == DATA_W'($past(rd) + 1'b1);
   endproperty
   a_inc_to_w: assert property (p_inc_to_w) // see RULE9
      else $error("increment to acc wrong");
   property p_branch_time;
      accept && instr.op == OP_UNCONDITIONAL_BRANCH |-> ##9 done_reg;
   endproperty
   a_branch_time: assert property (p_branch_time) // see RULE10
      else $error("branch not two cycles");
   property p_preclear_hold;
      (op_pa || op_pb) && !pre_clear_now |=> $stable(powerdown_flag_reg);
   endproperty
   a_preclear_hold: assert property (p_preclear_hold) // see RULE15
      else $error("flags moved without dog clear");
   property p_halt;
      op_halt |=> power_down_reg && powerdown_flag_reg && dog_clear_reg;
   endproperty
   a_halt: assert property (p_halt) // see RULE16
      else $error("halt did not power down");
   property p_kick;
      op_kick && !dog_timeout
         |=> dog_clear_reg && !dog_expiry_flag_reg && !powerdown_flag_reg;
   endproperty
   a_kick: assert property (p_kick) // see RULE17
      else $error("kick did not clear flags");

   c_skip: cover property (exec && skip);
   c_pcl_and_skip: cover property (exec && pcl_wr && skip);
   c_preclear: cover property (pre_clear_now);
   c_table: cover property (exec && ir_reg.op == OP_TABLE_FETCH_FINAL_PAGE);
endmodule // mbe_exec
`default_nettype wire

// ### tb/mbe_pm_model.sv
// program memory model for table fetches
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// program memory
// ****************************************
module mbe_pm_model
   import mbe_pkg::*;
(
   // address from the executor
   input wire logic [PC_W-1:0] pm_addr,
   // fetched word
   output logic [PM_W-1:0] pm_data
);
   // halves differ per page and per byte, so a swapped pair shows
   assign pm_data = {pm_addr[11:5], ~pm_addr[7:0]};
endmodule // mbe_pm_model
`default_nettype wire

// ### tb/mbe_exec_tb.sv
// self-checking bench of the move, skip, branch and watchdog executor
`timescale 1ns/1ps
`default_nettype none
module mbe_exec_tb
   import mbe_pkg::*;
   ;
   logic clk, rst_b, instr_valid, instr_ack_reg, done_reg, skip_reg;
   logic dog_timeout, wake_pin, dog_clear_reg, power_down_reg;
   logic dog_expiry_flag_reg, powerdown_flag_reg, int_exit_reg;
   mbe_instr_t instr;
   logic [PC_W-1:0] pm_addr_reg, pc_reg;
   logic [PM_W-1:0] pm_data;
   logic [DATA_W-1:0] tblp, acc_reg;
   logic [PM_W-DATA_W-1:0] table_high_latch_reg;
   int miscompares, checks_done, dog_cnt, iexit_cnt;

   mbe_exec i_dut (.clk, .rst_b, .instr_valid, .instr, .instr_ack_reg,
      .done_reg, .skip_reg, .pm_addr_reg, .pm_data, .tblp, .dog_timeout,
      .wake_pin, .dog_clear_reg, .power_down_reg, .dog_expiry_flag_reg,
      .powerdown_flag_reg, .acc_reg, .pc_reg, .table_high_latch_reg,
      .int_exit_reg);
   mbe_pm_model i_pm (.pm_addr(pm_addr_reg), .pm_data(pm_data));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk) begin
      if (dog_clear_reg === 1'b1) dog_cnt++;
      if (int_exit_reg === 1'b1) iexit_cnt++;
   end

   // ****************************************
   // checking and closing
   // ****************************************
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      checks_done++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task automatic print_verdict;
      $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // offer one instruction, then judge its length in clocks and its skip
   task automatic run(input mbe_op_t op, input logic [7:0] a,
         input logic [2:0] b, input logic [7:0] x, input int n,
         input logic sk, input logic [11:0] t = 12'h000);
      int c;
      logic s;
      c = 0;
      s = 1'b0;
      @(posedge clk);
      instr <= '{op: op, addr: a, bit_sel: b, imm: x, target: t};
      instr_valid <= 1'b1;
      do begin
         @(posedge clk);
         c++;
      end while (instr_ack_reg !== 1'b1 && c < 40);
      if (c >= 40) begin
         miscompares++;
         print_verdict();
      end
      instr_valid <= 1'b0;
      c = 0;
      do begin
         @(posedge clk);
         c++;
         if (skip_reg === 1'b1) s = 1'b1;
      end while (done_reg !== 1'b1 && c < 40);
      if (c >= 40) begin
         miscompares++;
         print_verdict;
      end
      chk(16'(c), 16'(CLK_PER_ICYC * n));
      chk(16'(s), 16'(sk));
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v, input int n);
      run(OP_TRANSFER_X_TO_A, 8'h00, 3'h0, v, 1, 1'b0);
      run(OP_TRANSFER_A_TO_M, a, 3'h0, 8'h00, n, 1'b0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      run(OP_TRANSFER_M_TO_A, a, 3'h0, 8'h00, 1, 1'b0);
      chk(16'(acc_reg), 16'(e));
   endtask

   function automatic logic [14:0] pmw(input logic [11:0] a);
      return {a[11:5], ~a[7:0]};
   endfunction

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_move_bit;
      wr(8'h20, 8'h5A, 1);
      run(OP_TRANSFER_X_TO_A, 8'h00, 3'h0, 8'h00, 1, 1'b0);
      rd(8'h20, 8'h5A);
      run(OP_BIT_SET, 8'h20, 3'h7, 8'h00, 1, 1'b0);
      run(OP_BIT_CLEAR, 8'h20, 3'h1, 8'h00, 1, 1'b0);
      rd(8'h20, 8'hD8);
      chk(16'({dog_expiry_flag_reg, powerdown_flag_reg}), 16'h0);
      wr(8'h06, 8'h45, 2);
      chk(16'(pc_reg[7:0]), 16'h0045);
   endtask

   task automatic t_skip;
      wr(8'h21, 8'h00, 1);
      run(OP_SKIP_IF_BYTE_ZERO, 8'h21, 3'h0, 8'h00, 2, 1'b1);
      run(OP_SKIP_IF_BYTE_ZERO, 8'h20, 3'h0, 8'h00, 1, 1'b0);
      run(OP_SKIP_ZERO_WITH_COPY, 8'h21, 3'h0, 8'h00, 2, 1'b1);
      chk(16'(acc_reg), 16'h0000);
      run(OP_SKIP_ZERO_WITH_COPY, 8'h20, 3'h0, 8'h00, 1, 1'b0);
      chk(16'(acc_reg), 16'h00D8);
      run(OP_SKIP_BIT_ZERO, 8'h20, 3'h0, 8'h00, 2, 1'b1);
      run(OP_SKIP_BIT_ZERO, 8'h20, 3'h7, 8'h00, 1, 1'b0);
      run(OP_SKIP_BIT_ONE, 8'h20, 3'h3, 8'h00, 2, 1'b1);
      run(OP_SKIP_BIT_ONE, 8'h20, 3'h0, 8'h00, 1, 1'b0);
   endtask

   task automatic t_incdec;
      wr(8'h22, 8'hFF, 1);
      run(OP_INC_SKIP_ZERO, 8'h22, 3'h0, 8'h00, 2, 1'b1);
      rd(8'h22, 8'h00);
      run(OP_DEC_SKIP_ZERO_TO_W, 8'h22, 3'h0, 8'h00, 1, 1'b0);
      chk(16'(acc_reg), 16'h00FF);
      rd(8'h22, 8'h00);
      wr(8'h23, 8'h01, 1);
      run(OP_DEC_SKIP_ZERO, 8'h23, 3'h0, 8'h00, 2, 1'b1);
      run(OP_INC_SKIP_ZERO_TO_W, 8'h22, 3'h0, 8'h00, 1, 1'b0);
      chk(16'(acc_reg), 16'h0001);
      rd(8'h23, 8'h00);
      wr(8'h06, 8'hFF, 2);
      run(OP_INC_SKIP_ZERO, 8'h06, 3'h0, 8'h00, 3, 1'b1);
      chk(16'(pc_reg[7:0]), 16'h0000);
      run(OP_BYTE_SET, 8'h24, 3'h0, 8'h00, 1, 1'b0);
      rd(8'h24, 8'hFF);
      run(OP_BYTE_CLEAR, 8'h24, 3'h0, 8'h00, 1, 1'b0);
      rd(8'h24, 8'h00);
   endtask

   task automatic t_branch_table;
      run(OP_UNCONDITIONAL_BRANCH, 8'h00, 3'h0, 8'h00, 2, 1'b0,
         12'h123);
      chk(16'(pc_reg), 16'h0123);
      run(OP_TABLE_FETCH_CURRENT_PAGE, 8'h30, 3'h0, 8'h00, 2, 1'b0);
      chk(16'(pm_addr_reg), 16'h0134);
      chk(16'(table_high_latch_reg), 16'(pmw(12'h134) >> 8));
      rd(8'h30, 8'(pmw(12'h134)));
      run(OP_TABLE_FETCH_FINAL_PAGE, 8'h31, 3'h0, 8'h00, 2, 1'b0);
      chk(16'(pm_addr_reg), 16'h0F34);
      chk(16'(table_high_latch_reg), 16'(pmw(12'hF34) >> 8));
      rd(8'h31, 8'(pmw(12'hF34)));
      run(OP_CALL, 8'h00, 3'h0, 8'h00, 2, 1'b0, 12'h200);
      chk(16'(pc_reg), 16'h0200);
      run(OP_SUBROUTINE_EXIT, 8'h00, 3'h0, 8'h00, 2, 1'b0);
      chk(16'(pc_reg), 16'h0128);
      run(OP_CALL, 8'h00, 3'h0, 8'h00, 2, 1'b0, 12'h300);
      run(OP_RETURN_LITERAL, 8'h00, 3'h0, 8'h77, 2, 1'b0);
      chk(16'(acc_reg), 16'h0077);
      run(OP_CALL, 8'h00, 3'h0, 8'h00, 2, 1'b0, 12'h400);
      run(OP_INTERRUPT_EXIT, 8'h00, 3'h0, 8'h00, 2, 1'b0);
      chk(16'(pc_reg), 16'h012A);
      chk(16'(iexit_cnt), 16'h0001);
      run(OP_NIBBLE_EXCHANGE, 8'h20, 3'h0, 8'h00, 1, 1'b0);
      run(OP_NIBBLE_EXCHANGE_TO_W, 8'h20, 3'h0, 8'h00, 1, 1'b0);
      chk(16'(acc_reg), 16'h00D8);
      rd(8'h20, 8'h8D);
   endtask

   task automatic dog_pulse;
      @(posedge clk);
      dog_timeout <= 1'b1;
      @(posedge clk);
      dog_timeout <= 1'b0;
   endtask

   task automatic t_dog;
      logic s;
      int d;
      s = 1'b0;
      run(OP_HALT, 8'h00, 3'h0, 8'h00, 1, 1'b0);
      chk(16'({power_down_reg, dog_expiry_flag_reg, powerdown_flag_reg}),
         16'h0005);
      // powered down: an offer must sit unanswered
      @(posedge clk);
      instr <= '0;
      instr_valid <= 1'b1;
      repeat (12) begin
         @(posedge clk);
         if (instr_ack_reg === 1'b1) s = 1'b1;
      end
      chk(16'(s), 16'h0);
      wake_pin <= 1'b1;
      run(OP_NOP, 8'h00, 3'h0, 8'h00, 1, 1'b0);
      wake_pin <= 1'b0;
      chk(16'(power_down_reg), 16'h0);
      dog_pulse();
      d = dog_cnt;
      run(OP_WATCHDOG_PRECLEAR_A, 8'h00, 3'h0, 8'h00, 1, 1'b0);
      chk(16'({dog_expiry_flag_reg, powerdown_flag_reg}), 16'h3);
      chk(16'(dog_cnt - d), 16'h0);
      run(OP_WATCHDOG_PRECLEAR_B, 8'h00, 3'h0, 8'h00, 1, 1'b0);
      chk(16'({dog_expiry_flag_reg, powerdown_flag_reg}), 16'h0);
      chk(16'(dog_cnt - d), 16'h1);
      dog_pulse();
      run(OP_WATCHDOG_KICK, 8'h00, 3'h0, 8'h00, 1, 1'b0);
      chk(16'({dog_expiry_flag_reg, powerdown_flag_reg}), 16'h0);
      chk(16'(dog_cnt - d), 16'h2);
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      rst_b = 1'b0;
      instr_valid = 1'b0;
      instr = '0;
      tblp = 8'h34;
      dog_timeout = 1'b0;
      wake_pin = 1'b0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      t_move_bit();
      t_skip();
      t_incdec();
      t_branch_table();
      t_dog();
      print_verdict();
   end
endmodule // mbe_exec_tb
`default_nettype wire
